// [verilog/hpd_config.sv]
// Hub port-disable and upstream current configuration bank with port renumbering
`timescale 1ns/1ns
`default_nettype none

//Contract
//- Self-powered mode disables ports set in the self-powered disable byte.
//- Bus-powered mode disables ports set in the bus-powered disable byte.
//- Bit n, n 1..5, controls port n; one disables, zero keeps.
//- Bits 7 and 6 reserved; bit 0 reserved and held zero.
//- Any combination allowed; report enabled count and renumber active ports.
//- Self-powered current draw is the self-powered byte times 2 mA.
//- Bus-powered current draw is the bus-powered byte times 2 mA.
//- Compound device with zero-current peripheral: values include its draw.
module hpd_config
    import hpd_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire hpd_cfg_req_t cfg_req,
    input wire logic self_powered,
    input wire logic compound_dev,
    input wire logic periph_zero_ma,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    output hpd_status_t status
);

    hpd_state_t s_r;
    hpd_state_t s_nxt;

    // Disable byte in effect for the current mode
    logic [7:0] sel_pdis;
    logic [7:0] sel_cur;
    logic [HPD_NPORTS-1:0] dis_w;

    assign sel_pdis = s_r.self_mode ? s_r.pdis_self : s_r.pdis_bus;
    assign sel_cur = s_r.self_mode ? s_r.cur_self : s_r.cur_bus;

    // One disable line per downstream port, port n from bit n
    genvar gi;
    generate
        for (gi = 0; gi < HPD_NPORTS; gi++) begin : g_port
            assign dis_w[gi] = sel_pdis[HPD_PORT_LO + gi];
        end
    endgenerate

    // Next-state logic: register loads, read-back, derived port view.
    // The port view is derived from registered bytes and mode, so it
    // trails a byte write or a mode change by one extra clock; this
    // keeps the renumbering network off the load path.
    always_comb begin
        logic [2:0] k;
        logic [HPD_NPORTS-1:0] en;
        k = '0;
        en = '0;
        s_nxt = s_r;
        if (ce) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.self_mode = self_powered;
            // Byte load; reserved bits forced to zero on the way in
            if (cfg_req.wr) begin
                if (cfg_req.addr == HPD_OFS_PDIS_SELF) begin
                    s_nxt.pdis_self = cfg_req.wdata & HPD_PDIS_WMASK;
                end else if (cfg_req.addr == HPD_OFS_PDIS_BUS) begin
                    s_nxt.pdis_bus = cfg_req.wdata & HPD_PDIS_WMASK;
                end else if (cfg_req.addr == HPD_OFS_CUR_SELF) begin
                    s_nxt.cur_self = cfg_req.wdata;
                end else if (cfg_req.addr == HPD_OFS_CUR_BUS) begin
                    s_nxt.cur_bus = cfg_req.wdata;
                end
            end
            // Read-back; unmapped offsets answer zero
            if (cfg_req.rd) begin
                s_nxt.rvalid = 1'b1;
                if (cfg_req.addr == HPD_OFS_PDIS_SELF) begin
                    s_nxt.rdata = s_r.pdis_self;
                end else if (cfg_req.addr == HPD_OFS_PDIS_BUS) begin
                    s_nxt.rdata = s_r.pdis_bus;
                end else if (cfg_req.addr == HPD_OFS_CUR_SELF) begin
                    s_nxt.rdata = s_r.cur_self;
                end else if (cfg_req.addr == HPD_OFS_CUR_BUS) begin
                    s_nxt.rdata = s_r.cur_bus;
                end else begin
                    s_nxt.rdata = '0;
                end
            end
            // Enabled ports are those not disabled in the selected byte
            en = ~dis_w;
            s_nxt.st.self_mode = s_r.self_mode;
            s_nxt.st.port_en = en;
            // Renumber: logical slot k takes the k-th enabled port
            s_nxt.st.port_map = '0;
            for (int i = 0; i < HPD_NPORTS; i++) begin
                if (en[i]) begin
                    s_nxt.st.port_map[k] = 3'(i + HPD_PORT_LO);
                    k = k + 3'd1;
                end
            end
            s_nxt.st.port_count = k;
            // Upstream draw in 2 mA steps
            s_nxt.st.max_power = sel_cur;
            s_nxt.st.current_ma = 9'(sel_cur) << HPD_CUR_SHIFT;
            // Flags that the current bytes must cover the peripheral too
            s_nxt.st.incl_periph = compound_dev & periph_zero_ma;
        end
    end

    // State register; reset clears the port view to no ports enabled, and the reset bytes enable all ports in bus mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r.pdis_self <= HPD_RST_PDIS_SELF;
            s_r.pdis_bus <= HPD_RST_PDIS_BUS;
            s_r.cur_self <= HPD_RST_CUR_SELF;
            s_r.cur_bus <= HPD_RST_CUR_BUS;
            s_r.self_mode <= 1'b0;
            s_r.rdata <= '0;
            s_r.rvalid <= 1'b0;
            s_r.st <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign cfg_rdata = s_r.rdata;
    assign cfg_rvalid = s_r.rvalid;
    assign status = s_r.st;

    // Helper for the renumbering check: first enabled physical port
    logic [2:0] first_en;
    always_comb begin
        first_en = '0;
        for (int i = HPD_NPORTS - 1; i >= 0; i--) begin
            if (s_r.st.port_en[i]) begin
                first_en = 3'(i + HPD_PORT_LO);
            end
        end
    end

    // Helper for the renumbering check: last enabled physical port
    logic [2:0] last_en;
    always_comb begin
        last_en = '0;
        for (int i = 0; i < HPD_NPORTS; i++) begin
            if (s_r.st.port_en[i]) begin
                last_en = 3'(i + HPD_PORT_LO);
            end
        end
    end

    // Self-powered mode hides exactly the ports set in the self byte
    a_self_disable: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && s_r.self_mode)
        |=> (status.port_en == ~$past(s_r.pdis_self[HPD_PORT_HI:HPD_PORT_LO]))
    ) else $error("self-powered port mask wrong");

    // Bus-powered mode hides exactly the ports set in the bus byte
    a_bus_disable: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && !s_r.self_mode)
        |=> (status.port_en == ~$past(s_r.pdis_bus[HPD_PORT_HI:HPD_PORT_LO]))
    ) else $error("bus-powered port mask wrong");

    // Port 1 follows bit 1 of the byte in effect
    a_bit_one_port: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && sel_pdis[HPD_PORT_LO]) |=> !status.port_en[0]
    ) else $error("bit 1 does not disable port 1");

    // A written self disable byte keeps its port bits and clears the rest
    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.wr && cfg_req.addr == HPD_OFS_PDIS_SELF)
        |=> (s_r.pdis_self[0] == 1'b0) && (s_r.pdis_self[7:6] == 2'b00)
            && (s_r.pdis_self[5:1] == $past(cfg_req.wdata[5:1]))
    ) else $error("self disable byte stored wrongly");

    // Reported count equals the number of enabled ports
    a_port_count: assert property (
        @(posedge clk) disable iff (!resetn)
        status.port_count == 3'($countones(status.port_en))
    ) else $error("port count mismatch");

    // Logical port 1 is the lowest enabled physical port
    a_renumber_first: assert property (
        @(posedge clk) disable iff (!resetn)
        (status.port_count != 3'd0) |-> (status.port_map[0] == first_en)
    ) else $error("renumbering wrong for first slot");

    // Self-powered current is twice the self byte
    a_self_current: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && s_r.self_mode)
        |=> (status.current_ma == {1'b0, $past(s_r.cur_self)} << HPD_CUR_SHIFT)
    ) else $error("self-powered current wrong");

    // Bus-powered current is twice the bus byte
    a_bus_current: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && !s_r.self_mode)
        |=> (status.current_ma == {1'b0, $past(s_r.cur_bus)} << HPD_CUR_SHIFT)
    ) else $error("bus-powered current wrong");

    // Peripheral flag follows compound and zero-current inputs
    a_periph_flag: assert property (
        @(posedge clk) disable iff (!resetn)
        ce |=> (status.incl_periph == ($past(compound_dev) && $past(periph_zero_ma)))
    ) else $error("peripheral inclusion flag wrong");

    // Steady self mode for two enabled cycles selects the self pair
    a_mode_select: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && self_powered) ##1 (ce && self_powered)
        |=> (status.self_mode && status.max_power == $past(s_r.cur_self))
    ) else $error("power mode did not select self pair");

    // Frozen clock enable holds the whole port view
    a_ce_freeze: assert property (
        @(posedge clk) disable iff (!resetn)
        !ce |=> (status == $past(status)) && !cfg_rvalid == !$past(cfg_rvalid)
    ) else $error("state moved while clock enable low");

    // A taken read raises valid on the very next edge
    a_read_valid: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.rd) |=> cfg_rvalid
    ) else $error("read valid missing");

    // Valid is a single pulse: no read taken means no valid next
    a_valid_pulse: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && !cfg_req.rd) |=> !cfg_rvalid
    ) else $error("read valid stretched");

    // Self disable byte reads back as stored
    a_read_pdis_self: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.rd && cfg_req.addr == HPD_OFS_PDIS_SELF)
        |=> (cfg_rdata == $past(s_r.pdis_self))
    ) else $error("self disable read-back wrong");

    // Bus disable byte reads back as stored
    a_read_pdis_bus: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.rd && cfg_req.addr == HPD_OFS_PDIS_BUS)
        |=> (cfg_rdata == $past(s_r.pdis_bus))
    ) else $error("bus disable read-back wrong");

    // Self current byte reads back as stored
    a_read_cur_self: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.rd && cfg_req.addr == HPD_OFS_CUR_SELF)
        |=> (cfg_rdata == $past(s_r.cur_self))
    ) else $error("self current read-back wrong");

    // Bus current byte reads back as stored
    a_read_cur_bus: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.rd && cfg_req.addr == HPD_OFS_CUR_BUS)
        |=> (cfg_rdata == $past(s_r.cur_bus))
    ) else $error("bus current read-back wrong");

    // Offsets outside the bank answer zero, so stale data never leaks
    a_read_unmapped: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.rd && cfg_req.addr != HPD_OFS_PDIS_SELF
            && cfg_req.addr != HPD_OFS_PDIS_BUS && cfg_req.addr != HPD_OFS_CUR_SELF
            && cfg_req.addr != HPD_OFS_CUR_BUS)
        |=> (cfg_rdata == 8'h00)
    ) else $error("unmapped read not zero");

    // Bus disable byte keeps its port bits and clears the reserved ones
    a_bus_reserved: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.wr && cfg_req.addr == HPD_OFS_PDIS_BUS)
        |=> (s_r.pdis_bus[0] == 1'b0) && (s_r.pdis_bus[7:6] == 2'b00)
            && (s_r.pdis_bus[5:1] == $past(cfg_req.wdata[5:1]))
    ) else $error("bus disable byte stored wrongly");

    // Self current byte is stored whole
    a_cur_self_load: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.wr && cfg_req.addr == HPD_OFS_CUR_SELF)
        |=> (s_r.cur_self == $past(cfg_req.wdata))
    ) else $error("self current byte stored wrongly");

    // Bus current byte is stored whole
    a_cur_bus_load: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_req.wr && cfg_req.addr == HPD_OFS_CUR_BUS)
        |=> (s_r.cur_bus == $past(cfg_req.wdata))
    ) else $error("bus current byte stored wrongly");

    // Last used logical slot holds the highest enabled physical port
    a_renumber_last: assert property (
        @(posedge clk) disable iff (!resetn)
        (status.port_count != 3'h0)
        |-> (status.port_map[status.port_count - 3'h1] == last_en)
    ) else $error("renumbering wrong for last slot");

    // Never more ports reported than exist
    a_count_bound: assert property (
        @(posedge clk) disable iff (!resetn)
        status.port_count <= 3'(HPD_NPORTS)
    ) else $error("port count out of range");

    // The view carries the mode it was built from
    a_mode_follow: assert property (
        @(posedge clk) disable iff (!resetn)
        ce |=> (status.self_mode == $past(s_r.self_mode))
    ) else $error("view mode does not follow internal mode");

    // Steady bus mode for two enabled cycles selects the bus pair
    a_bus_select: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && !self_powered) ##1 (ce && !self_powered)
        |=> (!status.self_mode && status.max_power == $past(s_r.cur_bus))
    ) else $error("power mode did not select bus pair");

endmodule // hpd_config

`default_nettype wire

// [verilog/hpd_pkg.sv]
// Constants and carrier types for the hub port-disable and power configuration bank
package hpd_pkg;

    // Configuration byte offsets
    localparam logic [7:0] HPD_OFS_PDIS_SELF = 8'h2a;
    localparam logic [7:0] HPD_OFS_PDIS_BUS = 8'h2b;
    localparam logic [7:0] HPD_OFS_CUR_SELF = 8'h2c;
    localparam logic [7:0] HPD_OFS_CUR_BUS = 8'h2d;

    // Reset values
    localparam logic [7:0] HPD_RST_PDIS_SELF = 8'h00;
    localparam logic [7:0] HPD_RST_PDIS_BUS = 8'h00;
    localparam logic [7:0] HPD_RST_CUR_SELF = 8'h01;
    localparam logic [7:0] HPD_RST_CUR_BUS = 8'h00;

    // Port-disable field layout: bits 5..1 map to ports 5..1
    localparam int HPD_NPORTS = 5;
    localparam int HPD_PORT_LO = 1;
    localparam int HPD_PORT_HI = 5;
    localparam logic [7:0] HPD_PDIS_WMASK = 8'h3e;

    // Current is reported in 2 mA steps, so a left shift by one
    localparam int HPD_CUR_STEP_MA = 2;
    localparam int HPD_CUR_SHIFT = 1;

    // Byte load port from the configuration loader
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hpd_cfg_req_t;

    // Port view handed to the enumeration logic
    typedef struct packed {
        logic self_mode;
        logic [HPD_NPORTS-1:0] port_en;
        logic [2:0] port_count;
        logic [HPD_NPORTS-1:0][2:0] port_map;
        logic [7:0] max_power;
        logic [8:0] current_ma;
        logic incl_periph;
    } hpd_status_t;

    // Complete module state
    typedef struct packed {
        logic [7:0] pdis_self;
        logic [7:0] pdis_bus;
        logic [7:0] cur_self;
        logic [7:0] cur_bus;
        logic self_mode;
        logic [7:0] rdata;
        logic rvalid;
        hpd_status_t st;
    } hpd_state_t;

endpackage

// [bench/hpd_loader_model.sv]
// Configuration loader model that programs the four bytes once go is seen
`timescale 1ns/1ns
`default_nettype none
module hpd_loader_model
    import hpd_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    output hpd_cfg_req_t req,
    output logic busy
);
    // Bit 0 of each disable byte stays zero; self byte 0x32 sits at the 100 mA ceiling
    localparam logic [31:0] IMG = 32'h05322004;
    logic [2:0] idx_r;
    logic [31:0] img_sh;
    // One byte per cycle, each held until the edge that takes it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idx_r <= 3'h0;
        end else if ((idx_r == 3'h0 && go) || busy) begin
            idx_r <= idx_r + 3'h1;
        end
    end
    assign busy = idx_r != 3'h0 && idx_r != 3'h5;
    assign img_sh = IMG >> {idx_r - 3'h1, 3'h0};
    assign req = busy ? hpd_cfg_req_t'{1'b1, 1'b0, 8'h29 + {5'h0, idx_r}, img_sh[7:0]} : '0;
endmodule // hpd_loader_model
`default_nettype wire

// [bench/tb_hpd_config.sv]
// Self-checking bench for the port-disable and current configuration bank
`timescale 1ns/1ns
`default_nettype none
module tb_hpd_config
    import hpd_pkg::*;
;
    logic clk, resetn, ce, go, self_powered, compound_dev, periph_zero_ma, cfg_rvalid, ld_busy;
    logic [7:0] cfg_rdata;
    hpd_cfg_req_t tb_req, ld_req;
    hpd_status_t status;
    int fail_count, compares;
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    hpd_loader_model u_hpd_loader_model (.clk(clk), .resetn(resetn), .go(go), .req(ld_req),
        .busy(ld_busy));
    // Loader owns the byte port while it runs; the bench stays quiet then
    hpd_config u_hpd_config (.clk(clk), .resetn(resetn), .ce(ce),
        .cfg_req(ld_busy ? ld_req : tb_req), .self_powered(self_powered),
        .compound_dev(compound_dev), .periph_zero_ma(periph_zero_ma),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .status(status));
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) tb_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) tb_req <= '0;
    endtask
    // Read data and its one-cycle valid land right after the taking edge
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk) tb_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) tb_req <= '0;
        #1 chk("read", {23'h0, cfg_rvalid, cfg_rdata}, {23'h0, 1'b1, e});
    endtask
    // Port view settles two enabled edges after a write or mode change
    task automatic vw(logic [4:0] en, logic [2:0] cnt, logic [14:0] map, logic [8:0] ma);
        repeat (3) @(posedge clk);
        #1 chk("view", {status.port_en, status.port_count, status.port_map, status.current_ma},
            {en, cnt, map, ma});
    endtask
    task automatic stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        repeat (2000) @(posedge clk);
        fail_count++;
        stop_test();
    end
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        go = 1'b0;
        tb_req = '0;
        self_powered = 1'b0;
        compound_dev = 1'b0;
        periph_zero_ma = 1'b0;
        fail_count = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h2a, 8'h00);
        rd(8'h2b, 8'h00);
        rd(8'h2c, 8'h01);
        rd(8'h2d, 8'h00);
        vw(5'h1f, 3'h5, 15'h58d1, 9'h000);
        $display("test reset done");
        // Loader image: bus pair drops port 5, self pair drops port 2
        @(posedge clk) go <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 10 && ld_busy; i++) @(posedge clk);
        vw(5'h0f, 3'h4, 15'h08d1, 9'h00a);
        chk("maxp", {24'h0, status.max_power}, 32'h5);
        @(posedge clk) self_powered <= 1'b1;
        vw(5'h1d, 3'h4, 15'h0b19, 9'h064);
        chk("mode", {31'h0, status.self_mode}, 32'h1);
        $display("test modes done");
        wr(8'h2a, 8'hff);
        rd(8'h2a, 8'h3e);
        vw(5'h00, 3'h0, 15'h0000, 9'h064);
        for (int n = 1; n <= 5; n++) begin
            wr(8'h2a, 8'h01 << n);
            repeat (3) @(posedge clk);
            #1 chk("en", {24'h0, status.port_en, status.port_count}, {24'h0, ~(5'h01 << (n - 1)), 3'h4});
        end
        wr(8'h2a, 8'h2a);
        vw(5'h0a, 3'h2, 15'h0022, 9'h064);
        $display("test disable done");
        wr(8'h2e, 8'hff);
        rd(8'h2e, 8'h00);
        rd(8'h2d, 8'h05);
        wr(8'h2c, 8'hff);
        vw(5'h0a, 3'h2, 15'h0022, 9'h1fe);
        // A write with the clock enable low must be dropped
        @(posedge clk) self_powered <= 1'b0;
        ce <= 1'b0;
        wr(8'h2d, 8'h77);
        ce <= 1'b1;
        vw(5'h0f, 3'h4, 15'h08d1, 9'h00a);
        @(posedge clk) compound_dev <= 1'b1;
        periph_zero_ma <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("periph", {31'h0, status.incl_periph}, 32'h1);
        @(posedge clk) periph_zero_ma <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("periph", {31'h0, status.incl_periph}, 32'h0);
        $display("test misc done");
        stop_test();
    end
endmodule // tb_hpd_config
`default_nettype wire
